// >>> flash_iface_pkg.sv
// How it works
// - Bits 3:0 hold dummy count 0..15
// - Count used by variable reads, sampled at CS fall
// - Mode cycles precede dummy: 0/4/2/1
// - Plain read zero, table read eight
// - Bit 7 selects 4-byte addressing
// - Enter-wide-address command sets bit 7
// - Bit 6 selects four-lane instructions
// - Only a register write with bit 6 high forces quad enable
// - Bit 5 enables lane-3 reset input
// - Bit 4 reserved, reads zero
// - Read 65h, write 71h decoded
// - Resets reload from non-volatile copy
// - Dummy count applies to six reads
package flash_iface_pkg;

  localparam logic [7:0] OP_READ   = 8'h03;
  localparam logic [7:0] OP_FAST   = 8'h0B;
  localparam logic [7:0] OP_DUAL   = 8'hBB;
  localparam logic [7:0] OP_QUAD   = 8'hEB;
  localparam logic [7:0] OP_DDRQ   = 8'hED;
  localparam logic [7:0] OP_ONCE   = 8'h4B;
  localparam logic [7:0] OP_PARAM  = 8'h5A;
  localparam logic [7:0] OP_RDANY  = 8'h65;
  localparam logic [7:0] OP_WRANY  = 8'h71;
  localparam logic [7:0] OP_WIDE   = 8'hB7;

  localparam logic [31:0] CFG_REG_ADDR = 32'h0000_0003;
  localparam logic [7:0]  RSVD_MASK    = 8'hEF;

  localparam logic [2:0] MODE_SINGLE = 3'h0;
  localparam logic [2:0] MODE_DUAL   = 3'h4;
  localparam logic [2:0] MODE_QUAD   = 3'h2;
  localparam logic [2:0] MODE_DDRQ   = 3'h1;
  localparam logic [3:0] PARAM_LAT   = 4'h8;
  localparam logic [3:0] PLAIN_LAT   = 4'h0;

  localparam logic [5:0] BYTE_BITS  = 6'h08;
  localparam logic [5:0] ADDR3_BITS = 6'h18;
  localparam logic [5:0] ADDR4_BITS = 6'h20;
  localparam logic [5:0] STEP_QUAD  = 6'h04;
  localparam logic [5:0] STEP_ONE   = 6'h01;

  typedef struct packed {
    logic       addr4;
    logic       four_lane_instr_mode;
    logic       lane3_rst;
    logic       rsvd;
    logic [3:0] dummy;
  } iface_cfg_t;

  typedef struct packed {
    logic       variable;
    logic [2:0] mode;
    logic [3:0] dummy;
  } read_lat_t;

  typedef enum {
    ST_IDLE, ST_CMD, ST_ADDR, ST_DUMMY, ST_DIN, ST_DOUT, ST_SKIP
  } phase_t;

endpackage

// >>> read_latency_sel.sv
`timescale 1ns/1ps
module read_latency_sel (
  // Command
  input  wire logic [7:0]            opcode,
  input  wire logic [3:0]            dummy,
  // Result
  output flash_iface_pkg::read_lat_t lat
);

  logic       is_var;
  logic [2:0] mode;
  logic [3:0] fixed;

  assign is_var = (opcode == flash_iface_pkg::OP_FAST)
                | (opcode == flash_iface_pkg::OP_DUAL)
                | (opcode == flash_iface_pkg::OP_QUAD)
                | (opcode == flash_iface_pkg::OP_DDRQ)
                | (opcode == flash_iface_pkg::OP_ONCE)
                | (opcode == flash_iface_pkg::OP_RDANY);
  assign mode = (opcode == flash_iface_pkg::OP_DUAL) ?
                  flash_iface_pkg::MODE_DUAL :
                (opcode == flash_iface_pkg::OP_QUAD) ?
                  flash_iface_pkg::MODE_QUAD :
                (opcode == flash_iface_pkg::OP_DDRQ) ?
                  flash_iface_pkg::MODE_DDRQ :
                  flash_iface_pkg::MODE_SINGLE;
  assign fixed = (opcode == flash_iface_pkg::OP_PARAM) ?
                   flash_iface_pkg::PARAM_LAT :
                   flash_iface_pkg::PLAIN_LAT;
  assign lat = '{variable: is_var, mode: mode,
                 dummy: is_var ? dummy : fixed};

endmodule

// >>> flash_iface_config.sv
`timescale 1ns/1ps
module flash_iface_config (
  // Clock and reset
  input  wire logic                       CORE_CLK,
  input  wire logic                       SRST,
  // Serial link pins
  input  wire logic                       SCK,
  input  wire logic                       CS_N,
  input  wire logic [3:0]                 IO_I,
  output logic [3:0]                      IO_O,
  output logic [3:0]                      IO_OE,
  // Neighbouring device logic
  input  wire logic [7:0]                 NV_CONFIG,
  input  wire logic                       SW_RESET,
  input  wire logic                       QUAD_MODE,
  output logic                            QUAD_FORCE,
  output logic                            HW_RESET,
  // Configuration state
  output flash_iface_pkg::iface_cfg_t     CFG,
  output flash_iface_pkg::iface_cfg_t     CMD_CFG,
  output flash_iface_pkg::read_lat_t      LAT
);

  logic [2:0]                  sck_s;
  logic [2:0]                  cs_s;
  logic [3:0]                  io_s0;
  logic [3:0]                  io_s1;
  flash_iface_pkg::phase_t     phase;
  flash_iface_pkg::phase_t     next_phase;
  logic [5:0]                  cnt;
  logic [5:0]                  next_cnt;
  logic [31:0]                 sh;
  logic [7:0]                  wr_data;
  logic [7:0]                  out_sh;
  logic                        wr_ok;
  logic                        is_wr;
  logic                        hit_q;
  flash_iface_pkg::read_lat_t  lat_now;
  flash_iface_pkg::iface_cfg_t nv_cfg;

  // Two stages before any logic looks at a pin
  always_ff @(posedge CORE_CLK) begin
    sck_s <= {sck_s[1:0], SCK};
    cs_s  <= {cs_s[1:0], CS_N};
    io_s0 <= IO_I;
    io_s1 <= io_s0;
  end

  wire sck_rise = sck_s[1] & ~sck_s[2];
  wire sck_fall = ~sck_s[1] & sck_s[2];
  wire cs_fall  = ~cs_s[1] & cs_s[2];
  wire cs_rise  = cs_s[1] & ~cs_s[2];

  // Lane 3 doubles as reset only while idle or quad is off
  wire hw_rst_cond = CFG.lane3_rst & ~io_s1[3]
                   & (cs_s[1] | ~QUAD_MODE);
  wire eng_rst = SRST | SW_RESET | hw_rst_cond;

  wire        four_lane = CMD_CFG.four_lane_instr_mode;
  wire [5:0]  step     = four_lane ? flash_iface_pkg::STEP_QUAD
                                   : flash_iface_pkg::STEP_ONE;
  wire [5:0]  cnt_inc  = cnt + step;
  wire [31:0] shift_in = four_lane ? {sh[27:0], io_s1}
                                   : {sh[30:0], io_s1[0]};
  wire [5:0]  abits    = CMD_CFG.addr4 ? flash_iface_pkg::ADDR4_BITS
                                       : flash_iface_pkg::ADDR3_BITS;
  wire [31:0] addr_val = CMD_CFG.addr4 ? shift_in
                                       : {8'h00, shift_in[23:0]};
  wire [7:0]  opcode   = shift_in[7:0];
  wire [5:0]  dummy6   = {2'h0, CMD_CFG.dummy};

  wire op_done   = sck_rise && phase == flash_iface_pkg::ST_CMD
                 && cnt_inc == flash_iface_pkg::BYTE_BITS;
  wire addr_done = sck_rise && phase == flash_iface_pkg::ST_ADDR
                 && cnt_inc == abits;
  wire din_done  = sck_rise && phase == flash_iface_pkg::ST_DIN
                 && cnt_inc == flash_iface_pkg::BYTE_BITS;
  wire wide_hit  = op_done && opcode == flash_iface_pkg::OP_WIDE;
  wire cfg_wr    = cs_rise && wr_ok && hit_q;
  wire out_start = sck_rise && next_phase == flash_iface_pkg::ST_DOUT
                 && phase != flash_iface_pkg::ST_DOUT;
  // Dummy bits shift into the word, so match it only while still in it
  wire rd_hit    = (phase == flash_iface_pkg::ST_ADDR)
                 ? addr_val == flash_iface_pkg::CFG_REG_ADDR : hit_q;

  assign nv_cfg = flash_iface_pkg::iface_cfg_t'(NV_CONFIG
                  & flash_iface_pkg::RSVD_MASK);

  always_comb begin
    next_phase = phase;
    next_cnt   = cnt_inc;
    case (phase)
      flash_iface_pkg::ST_CMD: begin
        if (cnt_inc == flash_iface_pkg::BYTE_BITS) begin
          next_cnt = 6'h00;
          if (opcode == flash_iface_pkg::OP_RDANY ||
              opcode == flash_iface_pkg::OP_WRANY) begin
            next_phase = flash_iface_pkg::ST_ADDR;
          end else begin
            next_phase = flash_iface_pkg::ST_SKIP;
          end
        end
      end
      flash_iface_pkg::ST_ADDR: begin
        if (cnt_inc == abits) begin
          next_cnt = 6'h00;
          if (is_wr) begin
            next_phase = flash_iface_pkg::ST_DIN;
          end else if (CMD_CFG.dummy == 4'h0) begin
            next_phase = flash_iface_pkg::ST_DOUT;
          end else begin
            next_phase = flash_iface_pkg::ST_DUMMY;
          end
        end
      end
      flash_iface_pkg::ST_DUMMY: begin
        next_cnt = cnt + 6'h01;
        if (cnt + 6'h01 == dummy6) begin
          next_phase = flash_iface_pkg::ST_DOUT;
        end
      end
      flash_iface_pkg::ST_DIN: begin
        if (cnt_inc == flash_iface_pkg::BYTE_BITS) begin
          next_phase = flash_iface_pkg::ST_SKIP;
        end
      end
      default: begin
        next_cnt = cnt;
      end
    endcase
  end

  // Command engine
  always_ff @(posedge CORE_CLK) begin
    if (eng_rst || cs_rise) begin
      phase <= flash_iface_pkg::ST_IDLE;
      cnt   <= 6'h00;
      sh    <= 32'h0000_0000;
    end else if (cs_fall) begin
      phase   <= flash_iface_pkg::ST_CMD;
      cnt     <= 6'h00;
      CMD_CFG <= CFG;
    end else if (sck_rise) begin
      phase <= next_phase;
      cnt   <= next_cnt;
      sh    <= shift_in;
    end
  end

  // Per-command captures
  always_ff @(posedge CORE_CLK) begin
    if (eng_rst || cs_fall) begin
      wr_ok <= 1'b0;
      is_wr <= 1'b0;
      hit_q <= 1'b0;
    end else begin
      if (op_done) begin
        is_wr <= opcode == flash_iface_pkg::OP_WRANY;
      end
      if (addr_done) begin
        hit_q <= addr_val == flash_iface_pkg::CFG_REG_ADDR;
      end
      if (din_done) begin
        wr_data <= shift_in[7:0];
        wr_ok   <= 1'b1;
      end
    end
  end

  read_latency_sel read_latency_sel_i (
    .opcode (opcode),
    .dummy  (CMD_CFG.dummy),
    .lat    (lat_now)
  );

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      LAT <= '0;
    end else if (op_done) begin
      LAT <= lat_now;
    end
  end

  // Write lands at chip-select rise so a torn frame changes nothing
  always_ff @(posedge CORE_CLK) begin
    QUAD_FORCE <= 1'b0;
    HW_RESET   <= hw_rst_cond;
    if (eng_rst) begin
      CFG <= nv_cfg;
    end else if (cfg_wr) begin
      CFG        <= flash_iface_pkg::iface_cfg_t'(wr_data
                    & flash_iface_pkg::RSVD_MASK);
      QUAD_FORCE <= wr_data[6];
    end else if (wide_hit) begin
      CFG.addr4 <= 1'b1;
    end
  end

  // Read-back: byte repeats for as long as the host clocks
  always_ff @(posedge CORE_CLK) begin
    if (eng_rst || cs_rise) begin
      IO_O   <= 4'h0;
      IO_OE  <= 4'h0;
      out_sh <= 8'h00;
    end else if (out_start) begin
      out_sh <= rd_hit ? CFG : 8'h00;
    end else if (sck_fall && phase == flash_iface_pkg::ST_DOUT) begin
      if (four_lane) begin
        IO_O   <= out_sh[7:4];
        IO_OE  <= 4'hF;
        out_sh <= {out_sh[3:0], out_sh[7:4]};
      end else begin
        IO_O   <= {2'h0, out_sh[7], 1'b0};
        IO_OE  <= 4'h2;
        out_sh <= {out_sh[6:0], out_sh[7]};
      end
    end
  end

  // Checks
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (SRST);

  sequence s_dummy_last;
    sck_rise && phase == flash_iface_pkg::ST_DUMMY
      && cnt + 6'h01 == dummy6;
  endsequence

  sequence s_out_begins;
    phase == flash_iface_pkg::ST_DOUT;
  endsequence

  a_reset_loads_nv: assert property (
    @(posedge CORE_CLK) disable iff (1'b0)
    SRST |=> CFG == $past(nv_cfg))
    else $error("Reset did not load stored settings");

  a_rsvd_bit_zero: assert property (
    CFG.rsvd == 1'b0)
    else $error("Reserved bit set");

  a_dummy_ends_out: assert property (
    s_dummy_last |=> s_out_begins)
    else $error("Dummy phase length wrong");

  a_dummy_never_short: assert property (
    (phase == flash_iface_pkg::ST_DUMMY && cnt + 6'h01 < dummy6)
      |=> phase != flash_iface_pkg::ST_DOUT)
    else $error("Data began before dummy count");

  a_snapshot_at_fall: assert property (
    (cs_fall && !eng_rst) |=> CMD_CFG == $past(CFG))
    else $error("Command settings not sampled");

  a_wide_sets_addr: assert property (
    (wide_hit && !eng_rst) |=> CFG.addr4)
    else $error("Wide address command ignored");

  a_write_applies: assert property (
    (cfg_wr && !eng_rst) |=> CFG == flash_iface_pkg::iface_cfg_t'(
      $past(wr_data) & flash_iface_pkg::RSVD_MASK))
    else $error("Register write lost");

  a_quad_forced: assert property (
    (cfg_wr && !eng_rst && wr_data[6])
      |=> QUAD_FORCE && CFG.four_lane_instr_mode)
    else $error("Quad enable not forced");

  a_fixed_latency: assert property (
    (op_done && opcode == flash_iface_pkg::OP_PARAM)
      |=> LAT.dummy == flash_iface_pkg::PARAM_LAT && !LAT.variable)
    else $error("Table read latency wrong");

  a_var_latency: assert property (
    (op_done && opcode == flash_iface_pkg::OP_DUAL)
      |=> LAT.variable && LAT.mode == flash_iface_pkg::MODE_DUAL
          && LAT.dummy == $past(CMD_CFG.dummy))
    else $error("Variable latency wrong");

  a_lane3_reset: assert property (
    (!CFG.lane3_rst) |=> !HW_RESET)
    else $error("Lane 3 reset while disabled");

endmodule

// >>> spi_host.sv
`timescale 1ns/1ps
module spi_host (
  // Link pins
  output logic            sck,
  output logic            cs_n,
  output logic [3:0]      io_i,
  // Device lanes
  input  wire logic [3:0] io_o
);
  // Lane 3 rests high: it doubles as an active-low reset
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    io_i = 4'hA;
  end
  // 320 ns cycle, far below every latency-code limit
  task automatic cyc();
    #160 sck = 1'b1;
    #160 sck = 1'b0;
  endtask
  // Mode 0, MSB first; q puts nibbles on all lanes
  task automatic send(input logic [31:0] v, input int n, input bit q);
    int i;
    i = n;
    if (cs_n) begin
      cs_n = 1'b0;
      #160;
    end
    while (i > 0) begin
      if (q) io_i = v[i-1 -: 4];
      else io_i[0] = v[i-1];
      i = q ? i - 4 : i - 1;
      cyc();
    end
  endtask
  // Sampled late in the high phase, past the sync delay
  task automatic get(output logic [7:0] v, input bit q);
    io_i = {1'b1, ~io_i[2:0]};
    repeat (q ? 2 : 8) begin
      #160 sck = 1'b1;
      #150 v = q ? {v[3:0], io_o} : {v[6:0], io_o[1]};
      #10 sck = 1'b0;
    end
  endtask
  // Released lanes flip so stale bits never pass for data
  task automatic stop();
    #160 cs_n = 1'b1;
    io_i = {1'b1, ~io_i[2:0]};
    #320;
  endtask
  task automatic pull3(input int t);
    io_i[3] = 1'b0;
    #t io_i[3] = 1'b1;
  endtask
endmodule

// >>> flash_iface_config_tb.sv
`timescale 1ns/1ps
`define CHK(s, e, a) begin \
  n_compared++; \
  if ((a) !== (e)) begin \
    n_errors++; \
    $display("Error %s: expected %h, seen %h", s, e, a); \
  end \
end
module flash_iface_config_tb;
  localparam logic [31:0] RA = flash_iface_pkg::CFG_REG_ADDR;
  localparam logic [7:0]  MK = flash_iface_pkg::RSVD_MASK;
  logic                        core_clk, srst, sck, cs_n, sw_reset;
  logic                        quad_mode, quad_force, hw_reset;
  logic [3:0]                  io_i, io_o, io_oe;
  logic [7:0]                  nv;
  flash_iface_pkg::iface_cfg_t cfg, cmd_cfg, m;
  flash_iface_pkg::read_lat_t  lat;
  int                          n_errors = 0;
  int                          n_compared = 0;
  int                          n_force = 0;
  int                          n_hw = 0;

  flash_iface_config flash_iface_config_i (
    .CORE_CLK(core_clk), .SRST(srst), .SCK(sck), .CS_N(cs_n),
    .IO_I(io_i), .IO_O(io_o), .IO_OE(io_oe), .NV_CONFIG(nv),
    .SW_RESET(sw_reset), .QUAD_MODE(quad_mode), .QUAD_FORCE(quad_force),
    .HW_RESET(hw_reset), .CFG(cfg), .CMD_CFG(cmd_cfg), .LAT(lat)
  );
  spi_host spi_host_i (.sck(sck), .cs_n(cs_n), .io_i(io_i), .io_o(io_o));

  initial core_clk = 1'b0;
  always #20 core_clk = ~core_clk;
  // Stand-in for the primary register's quad-enable bit
  always @(posedge core_clk) begin
    if (quad_force) begin
      quad_mode <= 1'b1;
      n_force <= n_force + 1;
    end
    if (hw_reset) n_hw <= n_hw + 1;
  end

  task automatic cmd(input logic [7:0] op, input logic [31:0] a);
    spi_host_i.send(op, 8, m.four_lane_instr_mode);
    spi_host_i.send(a, m.addr4 ? 32 : 24, m.four_lane_instr_mode);
  endtask
  task automatic wr(input logic [7:0] d, input logic [31:0] a);
    cmd(8'h71, a);
    spi_host_i.send(d, 8, m.four_lane_instr_mode);
    spi_host_i.stop();
    if (a == RA) m = d & MK;
    `CHK("cfg", m, cfg)
  endtask
  // Wrong dummy count shifts the byte, so readback checks it
  task automatic rd();
    logic [7:0] v;
    cmd(8'h65, RA);
    spi_host_i.send(32'h0, m.dummy, 1'b0);
    spi_host_i.get(v, m.four_lane_instr_mode);
    `CHK("oe", m.four_lane_instr_mode ? 4'hF : 4'h2, io_oe)
    `CHK("cmd_cfg", m, cmd_cfg)
    spi_host_i.stop();
    `CHK("rd", m, v)
  endtask

  task automatic t_regs();
    flash_iface_pkg::iface_cfg_t p;
    logic [7:0] d [3] = '{8'h1F, 8'h00, 8'h03};
    foreach (d[i]) begin
      p = m;
      wr(d[i], RA);
      `CHK("hold", p, cmd_cfg)
      rd();
    end
    wr(8'h2A, 32'h4);
  endtask
  task automatic t_lat();
    logic [7:0] op [8] = '{8'h03, 8'h0B, 8'hBB, 8'hEB,
                           8'hED, 8'h4B, 8'h5A, 8'h65};
    logic [2:0] md [8] = '{3'h0, 3'h0, 3'h4, 3'h2,
                           3'h1, 3'h0, 3'h0, 3'h0};
    logic [7:0] vr;
    logic [7:0] e;
    vr = 8'hBE;
    foreach (op[i]) begin
      spi_host_i.send(op[i], 8, 1'b0);
      spi_host_i.stop();
      e = {vr[i], md[i], vr[i] ? m.dummy : (i == 6 ? 4'h8 : 4'h0)};
      `CHK("lat", e, lat)
    end
  endtask
  task automatic t_wide();
    spi_host_i.send(8'hB7, 8, 1'b0);
    spi_host_i.stop();
    m.addr4 = 1'b1;
    `CHK("wide", m, cfg)
    rd();
  endtask
  task automatic t_qpi();
    wr(8'hC5, RA);
    `CHK("force", 1, n_force)
    rd();
    wr(8'h85, RA);
    `CHK("force", 1, n_force)
  endtask
  task automatic t_lane3();
    spi_host_i.pull3(400);
    repeat (8) @(posedge core_clk);
    `CHK("no_hw", 0, n_hw)
    wr(8'hA5, RA);
    spi_host_i.pull3(400);
    repeat (8) @(posedge core_clk);
    `CHK("hw", 1'b1, n_hw > 0)
    m = nv & MK;
    `CHK("hw_load", m, cfg)
  endtask
  task automatic t_sw();
    wr(8'h87, RA);
    @(posedge core_clk) sw_reset <= 1'b1;
    @(posedge core_clk) sw_reset <= 1'b0;
    repeat (4) @(posedge core_clk);
    m = nv & MK;
    `CHK("sw_load", m, cfg)
    rd();
  endtask

  task automatic finish_test();
    if (n_errors == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    srst = 1'b1;
    sw_reset = 1'b0;
    quad_mode = 1'b0;
    nv = 8'h1B;
    repeat (5) @(posedge core_clk);
    srst <= 1'b0;
    repeat (4) @(posedge core_clk);
    m = nv & MK;
    `CHK("reset", m, cfg)
    t_regs();
    t_lat();
    t_wide();
    t_qpi();
    t_lane3();
    t_sw();
    finish_test();
  end
  // Guard against a hung frame
  initial begin
    #2000000;
    n_errors++;
    finish_test();
  end
endmodule
